// [include/pdsg_regs.vh]
// Register offsets, field positions, reset values and timing counts for the peripheral clock gating block
`ifndef PDSG_REGS_VH
`define PDSG_REGS_VH
`define PDSG_NUM_PERIPH 34
`define PDSG_OFS_RUN_LO 8'h00
`define PDSG_OFS_RUN_HI 8'h04
`define PDSG_OFS_DS_LO 8'h08
`define PDSG_OFS_DS_HI 8'h0C
`define PDSG_OFS_GATE 8'h10
`define PDSG_OFS_STAT_LO 8'h14
`define PDSG_OFS_STAT_HI 8'h18
`define PDSG_OFS_MODE 8'h1C
`define PDSG_GATE_BIT 0
`define PDSG_MODE_DS_BIT 0
`define PDSG_RUN_RST 34'h000000000
`define PDSG_DS_RST 34'h000000000
`define PDSG_GATE_RST 1'b0
`define PDSG_EN_DELAY 5
`endif

// [logic/pdsg_enable_delay.v]
// One peripheral's run-enable delay counter and glitch-free clock gate enable
`timescale 1ns/100ps
module pdsg_enable_delay #(
   parameter DELAY = 5
) (
   input wire clk,
   input wire sys_rst,
   input wire runEnable,
   input wire dsActive,
   input wire dsKeep,
   output reg ready_ff,
   output reg clkOn_ff
);
   reg [3:0] cnt_ff;
   reg [3:0] nxt_cnt;
   always @* begin
      nxt_cnt = cnt_ff;
      if (!runEnable) begin
         nxt_cnt = 4'h0;
      end else if (cnt_ff != DELAY[3:0]) begin
         nxt_cnt = cnt_ff + 4'h1;
      end
   end
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= 4'h0;
         ready_ff <= 1'b0;
         clkOn_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ready_ff <= runEnable && (nxt_cnt == DELAY[3:0]);
         clkOn_ff <= runEnable && (!dsActive || dsKeep);
      end
   end
endmodule

// [logic/pdsg_top.v]
// Wishbone-controlled per-peripheral run and deep-sleep clock gating
`timescale 1ns/100ps
`include "pdsg_regs.vh"
// Notes on behaviour
// - Deep-sleep with gating stops unkept peripherals
// - Clock returns automatically on deep-sleep exit
// - Gating never resets peripheral state
// - Deep-sleep kept peripherals stay clocked
// - Switch off keeps settings but ignores them
// - Run-disabled peripheral gets no clock
// - Independent run and deep-sleep bit each peripheral
// - Switch off clocks like run mode
// - Run enables clear at reset
// - Enable takes five cycles; periphReady rises when done
module pdsg_top #(
   parameter NP = `PDSG_NUM_PERIPH,
   parameter EN_DELAY = `PDSG_EN_DELAY
) (
   input wire clk,
   input wire sys_rst,
   input wire cpuDeepSleep,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   output wire [NP-1:0] periphClkEn,
   output wire [NP-1:0] periphReady
);
   reg [63:0] runClkOn_ff;
   reg [63:0] dsKeepClock_ff;
   reg globalGatingSwitch_ff;
   reg dsSync1_ff;
   reg dsSync2_ff;
   wire dsActive;
   wire [63:0] readyVec;
   wire [63:0] clkVec;
   wire req;
   wire hit;
   reg [31:0] rdData;
   reg rdHit;

   // Next-state values and decoded write strobes
   reg [63:0] nxt_runClkOn;
   reg [63:0] nxt_dsKeepClock;
   reg nxt_globalGatingSwitch;
   reg nxt_ack;
   reg nxt_err;
   reg [31:0] nxt_datOut;
   wire [31:0] laneMask;
   wire [63:0] implMask;

   wire wrAccept;
   wire rdAccept;
   wire wrRunLo;
   wire wrRunHi;
   wire wrDsLo;
   wire wrDsHi;
   wire wrGate;
   genvar b;

   // Deep-sleep request comes from the processor domain boundary
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dsSync1_ff <= 1'b0;
         dsSync2_ff <= 1'b0;
      end else begin
         dsSync1_ff <= cpuDeepSleep;
         dsSync2_ff <= dsSync1_ff;
      end
   end
   assign dsActive = dsSync2_ff && globalGatingSwitch_ff;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

   always @* begin
      rdData = 32'h00000000;
      rdHit = 1'b1;
      case (wb_adr_i)
         `PDSG_OFS_RUN_LO: rdData = runClkOn_ff[31:0];
         `PDSG_OFS_RUN_HI: rdData = runClkOn_ff[63:32];
         `PDSG_OFS_DS_LO: rdData = dsKeepClock_ff[31:0];
         `PDSG_OFS_DS_HI: rdData = dsKeepClock_ff[63:32];
         `PDSG_OFS_GATE: rdData[`PDSG_GATE_BIT] = globalGatingSwitch_ff;
         `PDSG_OFS_STAT_LO: rdData = readyVec[31:0];
         `PDSG_OFS_STAT_HI: rdData = readyVec[63:32];
         `PDSG_OFS_MODE: rdData[`PDSG_MODE_DS_BIT] = dsActive;
         default: rdHit = 1'b0;
      endcase
   end
   assign hit = rdHit;

   // The registered ack masks the still-held request for one cycle
   assign wrAccept = req && hit && wb_we_i;
   assign rdAccept = req && hit && !wb_we_i;

   // Byte lanes widen to a bit mask so a partial write leaves the other lanes alone
   generate
      for (b = 0; b < 4; b = b + 1) begin : gLane
         assign laneMask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   endgenerate

   // Status and mode offsets are read-only: a write there is answered and dropped
   assign wrRunLo = wrAccept && (wb_adr_i == `PDSG_OFS_RUN_LO);
   assign wrRunHi = wrAccept && (wb_adr_i == `PDSG_OFS_RUN_HI);
   assign wrDsLo = wrAccept && (wb_adr_i == `PDSG_OFS_DS_LO);
   assign wrDsHi = wrAccept && (wb_adr_i == `PDSG_OFS_DS_HI);
   assign wrGate = wrAccept && (wb_adr_i == `PDSG_OFS_GATE) && wb_sel_i[0];

   // Run enables merge the written lanes into the held value
   always @* begin
      nxt_runClkOn = runClkOn_ff;
      if (wrRunLo) begin
         nxt_runClkOn[31:0] = (runClkOn_ff[31:0] & ~laneMask) | (wb_dat_i & laneMask);
      end
      if (wrRunHi) begin
         nxt_runClkOn[63:32] = (runClkOn_ff[63:32] & ~laneMask) | (wb_dat_i & laneMask);
      end
   end

   // Deep-sleep keep bits follow the same byte-lane rules
   always @* begin
      nxt_dsKeepClock = dsKeepClock_ff;
      if (wrDsLo) begin
         nxt_dsKeepClock[31:0] = (dsKeepClock_ff[31:0] & ~laneMask) | (wb_dat_i & laneMask);
      end
      if (wrDsHi) begin
         nxt_dsKeepClock[63:32] = (dsKeepClock_ff[63:32] & ~laneMask) | (wb_dat_i & laneMask);
      end
   end

   // Keep settings survive while the switch is off; only their effect is masked
   always @* begin
      nxt_globalGatingSwitch = globalGatingSwitch_ff;
      if (wrGate) begin
         nxt_globalGatingSwitch = wb_dat_i[`PDSG_GATE_BIT];
      end
   end

   always @* begin
      nxt_ack = req && hit;
      nxt_err = req && !hit;
      nxt_datOut = 32'h00000000;
      if (rdAccept) begin
         nxt_datOut = rdData;
      end
   end

   // Unimplemented peripheral bits are masked so they always read zero
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         runClkOn_ff <= {30'h0, `PDSG_RUN_RST};
      end else begin
         runClkOn_ff <= nxt_runClkOn & implMask;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dsKeepClock_ff <= {30'h0, `PDSG_DS_RST};
      end else begin
         dsKeepClock_ff <= nxt_dsKeepClock & implMask;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         globalGatingSwitch_ff <= `PDSG_GATE_RST;
      end else begin
         globalGatingSwitch_ff <= nxt_globalGatingSwitch;
      end
   end

   // Bus answer flops; read data is zero whenever no read is answered
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= nxt_ack;
         wb_err_o <= nxt_err;
         wb_dat_o <= nxt_datOut;
      end
   end

   // Clock gating only withholds edges; no reset reaches the peripheral here
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : gPer
         pdsg_enable_delay #(
            .DELAY(EN_DELAY)
         ) uDelay (
            .clk(clk),
            .sys_rst(sys_rst),
            .runEnable(runClkOn_ff[g]),
            .dsActive(dsActive),
            .dsKeep(dsKeepClock_ff[g]),
            .ready_ff(readyVec[g]),
            .clkOn_ff(clkVec[g])
         );
         assign implMask[g] = 1'b1;
      end

      // Padding keeps the 64-bit register views well defined
      for (g = NP; g < 64; g = g + 1) begin : gPad
         assign readyVec[g] = 1'b0;
         assign clkVec[g] = 1'b0;
         assign implMask[g] = 1'b0;
      end
   endgenerate

   assign periphClkEn = clkVec[NP-1:0];
   assign periphReady = readyVec[NP-1:0];
endmodule

// [verif/pdsg_monitor.sv]
// Bus and gating checks
`timescale 1ns/100ps
module pdsg_monitor #(parameter NP=34) (
   input wire clk,
   input wire sys_rst,
   input wire cpuDeepSleep,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire [3:0] wb_sel_i,
   input wire [NP-1:0] periphClkEn,
   input wire [NP-1:0] periphReady
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
wire tk=wb_cyc_i&wb_stb_i&!wb_ack_o&!wb_err_o;
sequence s_take; tk; endsequence
sequence s_run0;
tk&&wb_we_i&&wb_sel_i[0]&&wb_adr_i==8'h00&&wb_dat_i[0]&&!periphReady[0]&&!cpuDeepSleep;
endsequence
a_one_answer: assert property (s_take |=> wb_ack_o^wb_err_o) else $error("no answer");
a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
a_err_unmap: assert property (tk&&wb_adr_i>8'h1C |=> wb_err_o) else $error("no err");
a_idle_quiet: assert property (!(wb_cyc_i&&wb_stb_i) |=> !wb_ack_o&&!wb_err_o) else $error("stray");
a_dat_zero: assert property (!wb_ack_o |-> wb_dat_o==32'h0) else $error("dat");
a_run_clk: assert property (s_run0 |=> ##[0:1] periphClkEn[0]) else $error("no clk");
a_ready_wait: assert property (s_run0 |=> (!periphReady[0])[*5] ##[1:2] periphReady[0]) else $error("rdy");
a_off_both: assert property ($fell(periphReady[0]) |-> !periphClkEn[0]) else $error("clk on");
endmodule
bind pdsg_top pdsg_monitor #(.NP(NP)) u_mon(.*);

// [verif/pdsg_periph_model.sv]
// Peripheral stand-in: counters that advance only on enabled clocks
`timescale 1ns/100ps
module pdsg_periph_model #(
   parameter NP = 34
) (
   input wire clk,
   input wire rst,
   input wire [NP-1:0] clkEn,
   output logic [8*NP-1:0] tickCnt_ff
);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tickCnt_ff <= {(8*NP){1'b0}};
      end else begin
         for (int i = 0; i < NP; i++) begin
            if (clkEn[i]) begin
               tickCnt_ff[i*8 +: 8] <= tickCnt_ff[i*8 +: 8] + 8'h01;
            end
         end
      end
   end
endmodule

// [verif/pdsg_tb.sv]
// Randomised bench for peripheral clock gating
`timescale 1ns/100ps
`define CHK(n,x,a) begin compares++; if ((a)!==(x)) begin miscompares++; $display("unexpected %s %h %h",n,x,a); end end
module tb;
logic clk=0,sys_rst=1,ds=0,we=0,cyc=0,stb=0,e;
logic [7:0] adr=8'h00,t;
logic [31:0] wd=32'h0,rd;
logic [3:0] sel=4'hF;
logic [33:0] run,dsk,v;
wire [31:0] dato;
wire ack,err;
wire [33:0] ce,rdy;
wire [271:0] tk;
int miscompares=0,compares=0;
pdsg_top u_dut(.clk(clk),.sys_rst(sys_rst),.cpuDeepSleep(ds),.wb_adr_i(adr),.wb_dat_i(wd),.wb_sel_i(sel),
.wb_we_i(we),.wb_cyc_i(cyc),.wb_stb_i(stb),.wb_dat_o(dato),.wb_ack_o(ack),.wb_err_o(err),.periphClkEn(ce),
.periphReady(rdy));
pdsg_periph_model u_pm(.clk(clk),.rst(sys_rst),.clkEn(ce),.tickCnt_ff(tk));
initial forever #4 clk=~clk;
task finish_test;
if (miscompares==0&&compares>0)
$display("bench passed");
else
$display("bench failed");
$finish;
endtask
task bus(input logic w,input logic [7:0] a,input logic [31:0] d);
@(posedge clk); cyc<=1; stb<=1; we<=w; adr<=a; wd<=d;
do @(posedge clk); while (!(ack|err));
rd=dato; e=err; cyc<=0; stb<=0; we<=0;
endtask
task rd34(input logic [7:0] a);
bus(0,a,0); v[31:0]=rd; bus(0,a+8'h04,0); v[33:32]=rd[1:0];
endtask
task wr34(input logic [7:0] a,input logic [33:0] x);
bus(1,a,x[31:0]); bus(1,a+8'h04,{30'h0,x[33:32]});
endtask
function logic [33:0] expCe(input int g);
return g ? run&dsk : run;
endfunction
initial begin
void'($urandom(63518));
repeat(8) @(posedge clk);
sys_rst<=0;
rd34(8'h00); `CHK("run",34'h0,v)
`CHK("clk",34'h0,ce)
bus(0,8'h20,0); `CHK("err",1'b1,e)
run={2'($urandom),$urandom}; run[1:0]=2'h3;
dsk={2'($urandom),$urandom}; dsk[1]=0;
wr34(8'h00,run); `CHK("early",34'h0,rdy)
wr34(8'h08,dsk); repeat(8) @(posedge clk);
rd34(8'h00); `CHK("run",run,v)
`CHK("clk",run,ce)
`CHK("rdy",run,rdy)
rd34(8'h14); `CHK("stat",run,v)
for (int g=0;g<2;g++) begin
bus(1,8'h10,g); ds<=1; repeat(6) @(posedge clk);
`CHK("ds",expCe(g),ce)
bus(0,8'h1C,0); `CHK("mode",g[0],rd[0])
t=tk[15:8]; repeat(4) @(posedge clk); `CHK("hold",g?t:t+8'h04,tk[15:8])
ds<=0; repeat(6) @(posedge clk); `CHK("wake",run,ce)
`CHK("resume",g?t+8'h02:t+8'h0A,tk[15:8])
end
rd34(8'h08); `CHK("keep",dsk,v)
wr34(8'h00,34'h0); @(posedge clk); `CHK("off",34'h0,ce)
`CHK("rdyoff",34'h0,rdy)
finish_test;
end
initial begin
repeat(5000) @(posedge clk);
miscompares++;
finish_test;
end
endmodule
